// *** logic/icm_pkg.sv ***
// Constants, register map and state encoding of the bus arbitration master
package icm_pkg;
   // Register indices on the plain register port
   localparam logic [2:0] A_BAUD = 3'h0;
   localparam logic [2:0] A_BUF  = 3'h1;
   localparam logic [2:0] A_CON1 = 3'h2;
   localparam logic [2:0] A_SEQ  = 3'h3;
   localparam logic [2:0] A_STAT = 3'h4;
   localparam logic [2:0] A_FLAG = 3'h5;
   localparam logic [2:0] A_IEN  = 3'h6;
   // control_one fields
   localparam int C1_WRITE_COLLISION_FLAG = 7;
   localparam int C1_OV   = 6;
   localparam int C1_EN   = 5;
   // sequence_control fields
   localparam int SQ_ACKSTAT = 6;
   localparam int SQ_ACKDT   = 5;
   localparam int SQ_ACK     = 4;
   localparam int SQ_RCV     = 3;
   localparam int SQ_STOP    = 2;
   localparam int SQ_RST     = 1;
   localparam int SQ_START   = 0;
   // port_status fields
   localparam int ST_P  = 4;
   localparam int ST_S  = 3;
   localparam int ST_BF = 0;
   // irq flag and enable fields
   localparam int FL_PORT = 0;
   localparam int FL_COLL = 1;
   // Reset values and bit counts
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [4:0] RST_SEQ  = 5'h00;
   localparam logic [1:0] RST_IEN  = 2'h0;
   localparam logic [3:0] BIT_ACK  = 4'h8;
   localparam logic [3:0] BIT_RXL  = 4'h7;
   localparam logic [7:0] BRG_ONE  = 8'h01;
   localparam logic [3:0] BIT_ONE  = 4'h1;

   typedef enum logic [4:0] {
      S_IDLE    = 5'h00,
      S_ST_CHK  = 5'h01,
      S_ST_CNT  = 5'h02,
      S_ST_SDAL = 5'h03,
      S_RS_REL  = 5'h04,
      S_RS_SCLW = 5'h05,
      S_RS_CNT  = 5'h06,
      S_RS_SDAL = 5'h07,
      S_SP_SDA  = 5'h08,
      S_SP_C1   = 5'h09,
      S_SP_SCLW = 5'h0a,
      S_SP_C2   = 5'h0b,
      S_SP_CHK  = 5'h0c,
      S_SP_FIN  = 5'h0d,
      S_B_LOW   = 5'h0e,
      S_B_W     = 5'h0f,
      S_B_H     = 5'h10,
      S_AK_LOW  = 5'h11,
      S_AK_W    = 5'h12,
      S_AK_H    = 5'h13
   } icm_state_e;
endpackage

// *** logic/icm_master.sv ***
// Two-wire bus master with multi-master arbitration and collision recovery
// Function
// - Sleep: completed byte or address raises wake
// - Reset disables port, abandons transfer
// - Reset or disable clears start/stop flags
// - Busy bus: stop detection raises port interrupt
// - Released 1 read as 0: collision, idle
// - Arbitration checked in address, data, sequences
// - Collision: stop shifting, clear full, release
// - Collision in sequence: abort, clear sequence bit
// - After collision, stop on bus sets interrupt
// - Next buffer write restarts at first bit
// - Start with line low: abort, collision
// - Start: load count; SCL low is collision
// - Start: early SDA low, then SCL low
// - Restart: count, release SCL, check SDA
// - Restart: SCL falls before SDA driven: collision
// - Restart: drive SDA, count, drive SCL
// - Stop: SCL high, count, SDA low collision
// - Stop: SCL low before SDA floats: collision
// - Stop end: stop flag, then interrupt
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module icm_master
   import icm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Register port
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       we_i,
   input  wire logic       re_i,
   output logic      [7:0] rdata_o,
   // Bus pins
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   // Wake request
   output logic            wake_o
);
   icm_state_e st_ff;
   logic       sda_m_ff, sda_s, sda_q, scl_m_ff, scl_s, scl_q;
   logic [7:0] brg_ff, sh_ff, baud_ff, buf_ff, rd_ff;
   logic [3:0] bitc_ff;
   logic       sda_low_ff, scl_low_ff, rx_ff, ackstat_ff;
   logic       coll_ff, seq_done_ff, byte_done_ff, rx_done_ff, tx_go_ff;
   logic       en_ff, write_collision_flag_ff, ov_ff, ackdt_ff, bf_ff, pirq_ff, cirq_ff;
   logic       stop_det_ff, start_det_ff, wake_ff;
   logic [4:0] seq_ff;
   logic [1:0] ien_ff;
   logic       brg_z, coll_now, pend, idle_st, stop_edge, start_edge;

   // Pins are asynchronous to clk_i
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sda_m_ff <= 1'b1;
         sda_s    <= 1'b1;
         sda_q    <= 1'b1;
         scl_m_ff <= 1'b1;
         scl_s    <= 1'b1;
         scl_q    <= 1'b1;
      end else begin
         sda_m_ff <= sda_i;
         sda_s    <= sda_m_ff;
         sda_q    <= sda_s;
         scl_m_ff <= scl_i;
         scl_s    <= scl_m_ff;
         scl_q    <= scl_s;
      end
   end

   assign brg_z      = (brg_ff == RST_BYTE);
   assign idle_st    = (st_ff == S_IDLE);
   assign pend       = coll_ff | seq_done_ff | byte_done_ff | rx_done_ff;
   assign stop_edge  = scl_s & scl_q & sda_s & ~sda_q;
   assign start_edge = scl_s & scl_q & ~sda_s & sda_q;

   // Open-drain pins: only ever pull low
   assign sda_o    = 1'b0;
   assign scl_o    = 1'b0;
   assign sda_oe_o = sda_low_ff;
   assign scl_oe_o = scl_low_ff;
   assign rdata_o  = rd_ff;
   assign wake_o   = wake_ff;

   // Collision conditions per phase
   always_comb begin
      coll_now = 1'b0;
      case (st_ff)
         S_ST_CHK:  coll_now = ~sda_s | ~scl_s;
         S_ST_CNT:  coll_now = sda_s & ~scl_s;
         S_RS_SCLW: coll_now = scl_s & ~sda_s;
         S_RS_CNT:  coll_now = sda_s & ~scl_s;
         S_SP_C2:   coll_now = ~scl_s;
         S_SP_CHK:  coll_now = brg_z & ~sda_s;
         S_B_H:     coll_now = ~rx_ff & (bitc_ff < BIT_ACK)
                               & ~sda_low_ff & ~sda_s;
         S_AK_H:    coll_now = ~sda_low_ff & ~sda_s;
         default:   coll_now = 1'b0;
      endcase
   end

   // Sequencer: start, restart, stop, acknowledge and bit engine
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff        <= S_IDLE;
         brg_ff       <= RST_BYTE;
         sh_ff        <= RST_BYTE;
         bitc_ff      <= 4'h0;
         sda_low_ff   <= 1'b0;
         scl_low_ff   <= 1'b0;
         rx_ff        <= 1'b0;
         ackstat_ff   <= 1'b0;
         coll_ff      <= 1'b0;
         seq_done_ff  <= 1'b0;
         byte_done_ff <= 1'b0;
         rx_done_ff   <= 1'b0;
      end else begin
         coll_ff      <= 1'b0;
         seq_done_ff  <= 1'b0;
         byte_done_ff <= 1'b0;
         rx_done_ff   <= 1'b0;
         if (!en_ff) begin
            st_ff      <= S_IDLE;
            sda_low_ff <= 1'b0;
            scl_low_ff <= 1'b0;
         end else if (coll_now) begin
            st_ff      <= S_IDLE;
            sda_low_ff <= 1'b0;
            scl_low_ff <= 1'b0;
            coll_ff    <= 1'b1;
         end else begin
            case (st_ff)
               S_IDLE: begin
                  brg_ff <= baud_ff;
                  if (pend) begin
                     st_ff <= S_IDLE;
                  end else if (seq_ff[SQ_START]) begin
                     st_ff <= S_ST_CHK;
                  end else if (seq_ff[SQ_RST]) begin
                     sda_low_ff <= 1'b0;
                     st_ff      <= S_RS_REL;
                  end else if (seq_ff[SQ_STOP]) begin
                     sda_low_ff <= 1'b1;
                     st_ff      <= S_SP_SDA;
                  end else if (seq_ff[SQ_ACK]) begin
                     sda_low_ff <= ~ackdt_ff;
                     st_ff      <= S_AK_LOW;
                  end else if (seq_ff[SQ_RCV]) begin
                     rx_ff      <= 1'b1;
                     sda_low_ff <= 1'b0;
                     bitc_ff    <= 4'h0;
                     st_ff      <= S_B_LOW;
                  end else if (tx_go_ff) begin
                     rx_ff      <= 1'b0;
                     sh_ff      <= buf_ff;
                     sda_low_ff <= ~buf_ff[7];
                     bitc_ff    <= 4'h0;
                     st_ff      <= S_B_LOW;
                  end
               end
               S_ST_CHK: st_ff <= S_ST_CNT;
               S_ST_CNT: begin
                  if (!sda_s || brg_z) begin
                     sda_low_ff <= 1'b1;
                     brg_ff     <= baud_ff;
                     st_ff      <= S_ST_SDAL;
                  end else begin
                     brg_ff <= brg_ff - BRG_ONE;
                  end
               end
               S_ST_SDAL, S_RS_SDAL: begin
                  if (brg_z) begin
                     scl_low_ff  <= 1'b1;
                     seq_done_ff <= 1'b1;
                     st_ff       <= S_IDLE;
                  end else begin
                     brg_ff <= brg_ff - BRG_ONE;
                  end
               end
               S_RS_REL: begin
                  if (brg_z) begin
                     scl_low_ff <= 1'b0;
                     st_ff      <= S_RS_SCLW;
                  end else begin
                     brg_ff <= brg_ff - BRG_ONE;
                  end
               end
               S_RS_SCLW: begin
                  brg_ff <= baud_ff;
                  if (scl_s) begin
                     st_ff <= S_RS_CNT;
                  end
               end
               S_RS_CNT: begin
                  if (!sda_s || brg_z) begin
                     sda_low_ff <= 1'b1;
                     brg_ff     <= baud_ff;
                     st_ff      <= S_RS_SDAL;
                  end else begin
                     brg_ff <= brg_ff - BRG_ONE;
                  end
               end
               S_SP_SDA: begin
                  brg_ff <= baud_ff;
                  if (!sda_s) begin
                     st_ff <= S_SP_C1;
                  end
               end
               S_SP_C1, S_B_LOW, S_AK_LOW: begin
                  if (brg_z) begin
                     scl_low_ff <= 1'b0;
                     st_ff <= (st_ff == S_SP_C1) ? S_SP_SCLW :
                              (st_ff == S_B_LOW) ? S_B_W : S_AK_W;
                  end else begin
                     brg_ff <= brg_ff - BRG_ONE;
                  end
               end
               S_SP_SCLW, S_B_W, S_AK_W: begin
                  brg_ff <= baud_ff;
                  if (scl_s) begin
                     st_ff <= (st_ff == S_SP_SCLW) ? S_SP_C2 :
                              (st_ff == S_B_W) ? S_B_H : S_AK_H;
                  end
               end
               S_SP_C2: begin
                  if (brg_z) begin
                     sda_low_ff <= 1'b0;
                     brg_ff     <= baud_ff;
                     st_ff      <= S_SP_CHK;
                  end else begin
                     brg_ff <= brg_ff - BRG_ONE;
                  end
               end
               S_SP_CHK: begin
                  if (brg_z) begin
                     brg_ff <= baud_ff;
                     st_ff  <= S_SP_FIN;
                  end else begin
                     brg_ff <= brg_ff - BRG_ONE;
                  end
               end
               S_SP_FIN: begin
                  if (brg_z) begin
                     seq_done_ff <= 1'b1;
                     st_ff       <= S_IDLE;
                  end else begin
                     brg_ff <= brg_ff - BRG_ONE;
                  end
               end
               S_B_H: begin
                  if (brg_z) begin
                     scl_low_ff <= 1'b1;
                     brg_ff     <= baud_ff;
                     sh_ff      <= {sh_ff[6:0], sda_s};
                     bitc_ff    <= bitc_ff + BIT_ONE;
                     sda_low_ff <= ~rx_ff & (bitc_ff < BIT_RXL) & ~sh_ff[6];
                     if (!rx_ff && bitc_ff == BIT_ACK) begin
                        ackstat_ff   <= sda_s;
                        byte_done_ff <= 1'b1;
                        st_ff        <= S_IDLE;
                     end else if (rx_ff && bitc_ff == BIT_RXL) begin
                        rx_done_ff <= 1'b1;
                        st_ff      <= S_IDLE;
                     end else begin
                        st_ff <= S_B_LOW;
                     end
                  end else begin
                     brg_ff <= brg_ff - BRG_ONE;
                  end
               end
               S_AK_H: begin
                  if (brg_z) begin
                     scl_low_ff  <= 1'b1;
                     seq_done_ff <= 1'b1;
                     st_ff       <= S_IDLE;
                  end else begin
                     brg_ff <= brg_ff - BRG_ONE;
                  end
               end
               default: st_ff <= S_IDLE;
            endcase
         end
      end
   end

   // Bus monitor: start and stop detection
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stop_det_ff  <= 1'b0;
         start_det_ff <= 1'b0;
      end else if (!en_ff) begin
         stop_det_ff  <= 1'b0;
         start_det_ff <= 1'b0;
      end else if (stop_edge) begin
         stop_det_ff  <= 1'b1;
         start_det_ff <= 1'b0;
      end else if (start_edge) begin
         start_det_ff <= 1'b1;
         stop_det_ff  <= 1'b0;
      end
   end

   // Software registers; hardware sets win over software clears
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_ff    <= 1'b0;
         baud_ff  <= RST_BYTE;
         buf_ff   <= RST_BYTE;
         write_collision_flag_ff  <= 1'b0;
         ov_ff    <= 1'b0;
         ackdt_ff <= 1'b0;
         seq_ff   <= RST_SEQ;
         bf_ff    <= 1'b0;
         pirq_ff  <= 1'b0;
         cirq_ff  <= 1'b0;
         ien_ff   <= RST_IEN;
         tx_go_ff <= 1'b0;
         wake_ff  <= 1'b0;
      end else begin
         tx_go_ff <= 1'b0;
         if (we_i) begin
            case (addr_i)
               A_BAUD: baud_ff <= wdata_i;
               A_BUF: begin
                  if (idle_st && !pend && seq_ff == RST_SEQ && en_ff) begin
                     buf_ff   <= wdata_i;
                     bf_ff    <= 1'b1;
                     tx_go_ff <= 1'b1;
                  end else begin
                     write_collision_flag_ff <= 1'b1;
                  end
               end
               A_CON1: begin
                  write_collision_flag_ff <= write_collision_flag_ff & wdata_i[C1_WRITE_COLLISION_FLAG];
                  ov_ff   <= ov_ff & wdata_i[C1_OV];
                  en_ff   <= wdata_i[C1_EN];
               end
               A_SEQ: begin
                  ackdt_ff <= wdata_i[SQ_ACKDT];
                  // No queuing: sequence bits only taken when idle
                  if (idle_st && !pend && seq_ff == RST_SEQ) begin
                     seq_ff <= wdata_i[SQ_ACK:SQ_START];
                  end
               end
               A_FLAG: begin
                  pirq_ff <= pirq_ff & wdata_i[FL_PORT];
                  cirq_ff <= cirq_ff & wdata_i[FL_COLL];
               end
               A_IEN: ien_ff <= wdata_i[FL_COLL:FL_PORT];
               default: ;
            endcase
         end
         if (re_i && addr_i == A_BUF) begin
            bf_ff <= 1'b0;
         end
         if (!en_ff || coll_ff || seq_done_ff) begin
            seq_ff <= RST_SEQ;
         end
         if (coll_ff || byte_done_ff) begin
            bf_ff <= 1'b0;
         end
         if (rx_done_ff) begin
            buf_ff <= sh_ff;
            bf_ff  <= 1'b1;
            ov_ff  <= ov_ff | bf_ff;
            seq_ff <= RST_SEQ;
         end
         if (coll_ff) begin
            cirq_ff <= 1'b1;
         end
         if (seq_done_ff || byte_done_ff || rx_done_ff
             || (stop_edge && en_ff && start_det_ff)) begin
            pirq_ff <= 1'b1;
         end
         wake_ff <= pirq_ff & ien_ff[FL_PORT];
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_ff <= RST_BYTE;
      end else if (re_i) begin
         case (addr_i)
            A_BAUD:  rd_ff <= baud_ff;
            A_BUF:   rd_ff <= buf_ff;
            A_CON1:  rd_ff <= {write_collision_flag_ff, ov_ff, en_ff, 5'h00};
            A_SEQ:   rd_ff <= {1'b0, ackstat_ff, ackdt_ff, seq_ff};
            A_STAT:  rd_ff <= {3'h0, stop_det_ff, start_det_ff, 2'h0, bf_ff};
            A_FLAG:  rd_ff <= {6'h00, cirq_ff, pirq_ff};
            A_IEN:   rd_ff <= {6'h00, ien_ff};
            default: rd_ff <= RST_BYTE;
         endcase
      end else begin
         rd_ff <= RST_BYTE;
      end
   end

   property p_flags_clr;
      @(posedge clk_i) disable iff (!rst_n_i)
      !en_ff |=> !stop_det_ff && !start_det_ff;
   endproperty
   a_flags_clr: assert property (p_flags_clr) else $error("start/stop flag kept");

   property p_arb;
      @(posedge clk_i) disable iff (!rst_n_i)
      (en_ff && st_ff == S_B_H && !rx_ff && bitc_ff < BIT_ACK && !sda_low_ff && !sda_s)
      |=> (idle_st && coll_ff) ##1 cirq_ff;
   endproperty
   a_arb: assert property (p_arb) else $error("lost arbitration missed");

   property p_release;
      @(posedge clk_i) disable iff (!rst_n_i)
      coll_ff |-> !sda_oe_o && !scl_oe_o ##1 !bf_ff;
   endproperty
   a_release: assert property (p_release) else $error("lines held after collision");

   property p_seq_clr;
      @(posedge clk_i) disable iff (!rst_n_i)
      coll_ff |=> seq_ff == RST_SEQ;
   endproperty
   a_seq_clr: assert property (p_seq_clr) else $error("sequence bit kept");

   property p_start_low;
      @(posedge clk_i) disable iff (!rst_n_i)
      (en_ff && st_ff == S_ST_CHK && (!sda_s || !scl_s)) |=> idle_st ##1 cirq_ff;
   endproperty
   a_start_low: assert property (p_start_low) else $error("busy start not aborted");

   property p_start_end;
      @(posedge clk_i) disable iff (!rst_n_i)
      (en_ff && st_ff == S_ST_SDAL && brg_z) |=> scl_oe_o && sda_oe_o && seq_done_ff;
   endproperty
   a_start_end: assert property (p_start_end) else $error("start not completed");

   property p_stop_scl;
      @(posedge clk_i) disable iff (!rst_n_i)
      (en_ff && st_ff == S_SP_C2 && !scl_s) |=> coll_ff ##1 cirq_ff && !seq_ff[SQ_STOP];
   endproperty
   a_stop_scl: assert property (p_stop_scl) else $error("stop collision missed");

   property p_bus_stop;
      @(posedge clk_i) disable iff (!rst_n_i)
      (en_ff && start_det_ff && stop_edge) |=> pirq_ff && stop_det_ff && !start_det_ff;
   endproperty
   a_bus_stop: assert property (p_bus_stop) else $error("bus stop irq missed");

endmodule // icm_master

// *** dv/icm_bus_model.sv ***
// Other party on the shared two-wire bus: pull-ups and wired-AND lines
`timescale 1ns/1ps
module icm_bus_model (
   // Pull-downs from the master under test
   input  wire logic sda_oe_i,
   input  wire logic scl_oe_i,
   // Resolved line levels
   output logic      sda_o,
   output logic      scl_o
);
   logic hold_sda = 1'b0;
   logic drv_sda  = 1'b0;
   logic drv_scl  = 1'b0;

   // Released lines float high through the pull-ups
   assign sda_o = ~(sda_oe_i | hold_sda | drv_sda);
   assign scl_o = ~(scl_oe_i | drv_scl);

   // Own frame on a 64 ns link clock; lines stand still between frames
   task automatic frame_start_stop();
      #32 drv_sda = 1'b1;
      #32 drv_scl = 1'b1;
      #32 drv_scl = 1'b0;
      #32 drv_sda = 1'b0;
   endtask
endmodule // icm_bus_model

// *** dv/tb_top.sv ***
// Self-checking bench for the arbitration master
`timescale 1ns/1ps
module tb_top;
   import icm_pkg::*;
   logic       clk_i   = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       we_i    = 1'b0;
   logic       re_i    = 1'b0;
   logic       rd_pend = 1'b0;
   logic [2:0] addr_i  = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] rdata_o;
   logic [7:0] d;
   logic       sda_o, sda_oe_o, scl_o, scl_oe_o, wake_o, sda, scl;
   logic [7:0] exp_q[$];
   int         num_errors = 0;
   int         num_checks = 0;

   always #4 clk_i = ~clk_i;

   icm_master icm_master_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_i(scl), .scl_o(scl_o),
      .scl_oe_o(scl_oe_o), .wake_o(wake_o));
   icm_bus_model icm_bus_model_inst (.sda_oe_i(sda_oe_o), .scl_oe_i(scl_oe_o),
      .sda_o(sda), .scl_o(scl));

   task automatic chk(input logic [7:0] got, input logic [7:0] e);
      num_checks++;
      if (got !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      we_i    <= 1'b1;
      @(posedge clk_i);
      we_i    <= 1'b0;
   endtask

   // Expected value and mask are queued; the monitor compares one cycle later
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back(e & m);
      exp_q.push_back(m);
      @(posedge clk_i);
      addr_i <= a;
      re_i   <= 1'b1;
      @(posedge clk_i);
      re_i   <= 1'b0;
   endtask

   // Pins sampled away from the launching edge
   task automatic pins(input logic [7:0] e, input logic [7:0] m);
      @(negedge clk_i);
      chk({5'h00, wake_o, sda_oe_o, scl_oe_o} & m, e);
      chk({6'h00, sda_o, scl_o}, 8'h00);
   endtask

   always @(posedge clk_i) rd_pend <= re_i;
   always @(negedge clk_i) begin
      if (rd_pend) begin
         d = exp_q.pop_front();
         chk(rdata_o & exp_q.pop_front(), d);
      end
   end

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      // Whole sequence needs under 600 clocks; the 5000-clock limit allows over eight times that
      #40000;
      num_errors++;
      complete_run();
   end

   initial begin
      void'($urandom(32'hd532));
      idle(6);
      rst_n_i <= 1'b1;
      wr(3'h7, 8'($urandom));
      rd(3'h7, 8'h00, 8'hff);
      rd(A_CON1, 8'h00, 8'hff);
      rd(A_STAT, 8'h00, 8'hff);
      $display("test reset done");
      // Start while another party holds SDA low
      wr(A_BAUD, 8'h03);
      wr(A_CON1, 8'h20);
      icm_bus_model_inst.hold_sda <= 1'b1;
      wr(A_SEQ, 8'h01);
      idle(30);
      rd(A_FLAG, 8'h02, 8'h02);
      rd(A_SEQ, 8'h00, 8'h01);
      pins(8'h00, 8'h07);
      icm_bus_model_inst.hold_sda <= 1'b0;
      wr(A_FLAG, 8'h00);
      $display("test start collision done");
      // Foreign start and stop on a busy bus
      wr(A_IEN, 8'h01);
      icm_bus_model_inst.frame_start_stop();
      idle(10);
      rd(A_FLAG, 8'h01, 8'h01);
      rd(A_STAT, 8'h10, 8'h10);
      pins(8'h04, 8'h07);
      wr(A_FLAG, 8'h00);
      $display("test bus stop done");
      // Own start, then a lost data bit
      wr(A_SEQ, 8'h01);
      for (int i = 0; i < 200 && scl_oe_o !== 1'b1; i++) @(negedge clk_i);
      pins(8'h03, 8'h03);
      idle(4);
      rd(A_SEQ, 8'h00, 8'h01);
      d = 8'($urandom) | 8'h80;
      icm_bus_model_inst.hold_sda <= 1'b1;
      wr(A_BUF, d);
      idle(60);
      rd(A_STAT, 8'h00, 8'h01);
      rd(A_FLAG, 8'h02, 8'h02);
      pins(8'h00, 8'h03);
      icm_bus_model_inst.hold_sda <= 1'b0;
      wr(A_FLAG, 8'h00);
      // Rewrite restarts at the first bit, no write collision
      wr(A_BUF, 8'($urandom) & 8'h7f);
      for (int i = 0; i < 10 && sda_oe_o !== 1'b1; i++) @(negedge clk_i);
      pins(8'h02, 8'h02);
      rd(A_CON1, 8'h00, 8'h80);
      idle(250);
      $display("test data collision done");
      // Stop lost: SDA still low after release
      icm_bus_model_inst.hold_sda <= 1'b1;
      wr(A_SEQ, 8'h04);
      idle(100);
      rd(A_FLAG, 8'h02, 8'h02);
      rd(A_SEQ, 8'h00, 8'h04);
      pins(8'h00, 8'h03);
      icm_bus_model_inst.hold_sda <= 1'b0;
      $display("test stop collision done");
      // Disable, then reset in mid-run
      wr(A_CON1, 8'h00);
      rd(A_STAT, 8'h00, 8'h18);
      // Let the read data be compared before reset wipes it
      idle(2);
      rst_n_i <= 1'b0;
      idle(2);
      rst_n_i <= 1'b1;
      rd(A_CON1, 8'h00, 8'hff);
      rd(A_FLAG, 8'h00, 8'hff);
      idle(3);
      $display("test disable and reset done");
      complete_run();
   end
endmodule // tb_top
